// ===== hw/lcd_multiplex_drive.sv
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module lcd_multiplex_drive #(
	parameter int OSC_HALF_CYCLES = lcd_drive_pkg::OSC_HALF_CYCLES
) (
	// system
	input  wire logic                   clock,
	input  wire logic                   rst,
	// ahb-lite slave
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic [31:0]                 hrdata,
	// clock pins
	input  wire logic                   internal_oscillator_enable_pin,
	input  wire logic                   lcd_clk_in,
	output logic                        lcd_clk_out,
	output logic                        lcd_clk_oe,
	// cascade sync, open drain
	input  wire logic                   sync_in,
	output logic                        sync_out,
	output logic                        sync_oe,
	// panel drive
	output lcd_drive_pkg::drive_type    panel_drive,
	output logic                        divider_bypass
);
	import lcd_drive_pkg::*;

	// rows per frame half for a multiplex ratio
	function automatic logic [2:0] rows_of(input mux_type m);
		rows_of = {1'b0, m} + 3'h1;
	endfunction

	// clock ticks per phase: 24 / (2 * rows)
	function automatic logic [3:0] phase_len(input mux_type m);
		unique case (m)
			MUX_STATIC: phase_len = 4'hC;
			MUX_2:      phase_len = 4'h6;
			MUX_3:      phase_len = 4'h4;
			MUX_4:      phase_len = 4'h3;
		endcase
	endfunction

	// row addressed by a phase index
	function automatic logic [1:0] row_of(input logic [2:0] p, input mux_type m);
		if (p >= rows_of(m))
			row_of = 2'(p - rows_of(m));
		else
			row_of = p[1:0];
	endfunction

	function automatic logic is_ram(input logic [7:0] a);
		is_ram = (a >= RAM_BASE_OFS) && (a <= RAM_END_OFS);
	endfunction

	logic                            clk_tick;
	logic                            internal_sel;
	mode_type                        mode_ff;
	logic [NUM_BP-1:0][NUM_SEG-1:0]  ram_ff;
	logic [NUM_SEG-1:0]              latch_ff;
	logic [2:0]                      phase_ff;
	logic [3:0]                      sub_ff;
	logic                            sync_s1_ff;
	logic                            sync_s2_ff;
	logic                            sync_s3_ff;
	logic                            sync_oe_ff;
	drive_type                       drive_ff;
	logic                            bypass_ff;
	logic                            wr_pend_ff;
	logic [7:0]                      wr_addr_ff;
	logic [31:0]                     rdata_ff;
	logic                            addr_phase;
	logic [2:0]                      last_phase;
	logic                            sync_hit;
	logic                            phase_end;
	logic [2:0]                      nxt_phase;
	logic [2:0]                      wr_idx;
	logic [2:0]                      rd_idx;
	logic [7:0]                      rd_addr;

	lcd_clock_source #(
		.OSC_HALF_CYCLES(OSC_HALF_CYCLES)
	) u_clock_source (
		.clock                          (clock),
		.rst                            (rst),
		.internal_oscillator_enable_pin (internal_oscillator_enable_pin),
		.lcd_clk_in                     (lcd_clk_in),
		.lcd_clk_out                    (lcd_clk_out),
		.lcd_clk_oe                     (lcd_clk_oe),
		.clk_tick                       (clk_tick),
		.internal_sel                   (internal_sel)
	);

	// bus decode; only aligned word transfers are expected
	assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign rd_addr    = haddr[7:0];
	assign wr_idx     = 3'((wr_addr_ff - RAM_BASE_OFS) >> 2);
	assign rd_idx     = 3'((rd_addr - RAM_BASE_OFS) >> 2);

	// address phase capture for writes, data lands one cycle later
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
		end else begin
			wr_pend_ff <= addr_phase && hwrite;
			if (addr_phase)
				wr_addr_ff <= haddr[7:0];
		end
	end

	// drive configuration command, from software
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			mode_ff <= mode_type'(MODE_RESET); // RQ19
		else if (wr_pend_ff && wr_addr_ff == MODE_OFS)
			mode_ff <= mode_type'(hwdata[MODE_WIDTH-1:0]); // RQ16 RQ12 RQ18
	end

	// display ram rows: low word then high byte per row
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ram_ff <= '0;
		end else if (wr_pend_ff && is_ram(wr_addr_ff) && wr_addr_ff[1:0] == 2'h0) begin
			if (wr_idx[0])
				ram_ff[wr_idx[2:1]][NUM_SEG-1:32] <= hwdata[NUM_SEG-33:0];
			else
				ram_ff[wr_idx[2:1]][31:0] <= hwdata;
		end
	end

	// read data prepared in the address phase; unmapped reads give zero
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata_ff <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			rdata_ff <= 32'h0000_0000;
			if (rd_addr == MODE_OFS) begin
				rdata_ff[MODE_WIDTH-1:0] <= mode_ff;
			end else if (rd_addr == STATUS_OFS) begin
				rdata_ff[STAT_PHASE_LSB +: 3] <= phase_ff;
				rdata_ff[STAT_ROW_LSB +: 2]   <= row_of(phase_ff, mode_ff.mux);
				rdata_ff[STAT_INTOSC_BIT]     <= internal_sel;
				rdata_ff[STAT_BYPASS_BIT]     <= bypass_ff;
			end else if (is_ram(rd_addr) && rd_addr[1:0] == 2'h0) begin
				if (rd_idx[0])
					rdata_ff[NUM_SEG-33:0] <= ram_ff[rd_idx[2:1]][NUM_SEG-1:32];
				else
					rdata_ff <= ram_ff[rd_idx[2:1]][31:0];
			end
		end
	end

	// zero wait state slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_ff;

	// sync line from the cascade, two stages before any use
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync_s1_ff <= 1'b1;
			sync_s2_ff <= 1'b1;
			sync_s3_ff <= 1'b1;
		end else begin
			sync_s1_ff <= sync_in;
			sync_s2_ff <= sync_s1_ff;
			sync_s3_ff <= sync_s2_ff;
		end
	end

	// a falling sync from another device restarts us; our own echo lands
	// while already in the last phase and is ignored there
	assign last_phase = 3'((rows_of(mode_ff.mux) << 1) - 3'h1);
	assign sync_hit   = sync_s3_ff && !sync_s2_ff && (phase_ff != last_phase); // RQ21 RQ6
	assign phase_end  = clk_tick && (sub_ff >= phase_len(mode_ff.mux) - 4'h1);

	// next phase: rows in order, then the same rows inverted
	always_comb begin
		if (sync_hit)
			nxt_phase = last_phase; // RQ21
		else if (phase_end && phase_ff >= last_phase)
			nxt_phase = 3'h0; // RQ20
		else if (phase_end)
			nxt_phase = phase_ff + 3'h1; // RQ20
		else
			nxt_phase = phase_ff;
	end

	// phase sequencer, 2 x rows phases of 12 / rows ticks = 24 ticks a frame
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			phase_ff <= 3'h0;
			sub_ff   <= 4'h0;
		end else begin
			phase_ff <= nxt_phase;
			if (sync_hit || phase_end)
				sub_ff <= 4'h0; // RQ1
			else if (clk_tick)
				sub_ff <= sub_ff + 4'h1;
		end
	end

	// latch one ram row at each phase change and hold it through the phase
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			latch_ff <= '0;
		else if (nxt_phase != phase_ff)
			latch_ff <= ram_ff[row_of(nxt_phase, mode_ff.mux)]; // RQ7 RQ20
	end

	// sync is pulled low for the last phase so followers restart with us
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			sync_oe_ff <= 1'b0;
		else
			sync_oe_ff <= (nxt_phase == last_phase); // RQ6
	end

	assign sync_out = 1'b0;
	assign sync_oe  = sync_oe_ff;

	// level generation; a disabled display parks everything at the supply
	// so the panel never sees a dc offset
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			drive_ff <= {($bits(drive_type)){1'b1}}; // RQ19
		end else if (!mode_ff.enable) begin
			drive_ff <= {($bits(drive_type)){1'b1}}; // RQ19
		end else begin
			for (int i = 0; i < NUM_BP; i++) begin
				logic [1:0] src;
				logic       inv;
				src = 2'(i);
				inv = (phase_ff >= rows_of(mode_ff.mux)); // RQ22
				unique case (mode_ff.mux)
					MUX_STATIC: src = 2'h0; // RQ11
					MUX_2:      src = {1'b0, src[0]}; // RQ13
					MUX_3:      src = (src == 2'h3) ? 2'h1 : src; // RQ14
					MUX_4:      src = src; // RQ15
				endcase
				if (mode_ff.mux == MUX_STATIC)
					drive_ff.bp[i] <= inv ? LVL_LCD : LVL_VSS; // RQ10
				else if (src == row_of(phase_ff, mode_ff.mux))
					drive_ff.bp[i] <= inv ? LVL_VSS : LVL_LCD; // RQ9
				else if (mode_ff.half)
					drive_ff.bp[i] <= LVL_LOW; // RQ12
				else
					drive_ff.bp[i] <= inv ? LVL_HIGH : LVL_LOW; // RQ22
			end
			for (int s = 0; s < NUM_SEG; s++) begin
				logic inv_s;
				inv_s = (phase_ff >= rows_of(mode_ff.mux));
				if (mode_ff.mux == MUX_STATIC)
					drive_ff.seg[s] <= (latch_ff[s] ^ inv_s) ? LVL_LCD : LVL_VSS; // RQ8 RQ10
				else if (latch_ff[s])
					drive_ff.seg[s] <= inv_s ? LVL_LCD : LVL_VSS; // RQ8
				else if (mode_ff.half)
					drive_ff.seg[s] <= inv_s ? LVL_VSS : LVL_LCD; // RQ12 RQ18
				else
					drive_ff.seg[s] <= inv_s ? LVL_LOW : LVL_HIGH; // RQ22
			end
		end
	end

	// bias divider middle element shorted under half bias
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			bypass_ff <= 1'b0;
		else
			bypass_ff <= mode_ff.half; // RQ17
	end

	assign panel_drive    = drive_ff;
	assign divider_bypass = bypass_ff;

	// helper: ticks in a frame that saw no sync restart and no bus write
	logic [5:0] frame_ticks_ff;
	logic       frame_clean_ff;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			frame_ticks_ff <= 6'h00;
			frame_clean_ff <= 1'b0;
		end else if (phase_end && phase_ff == last_phase) begin
			frame_ticks_ff <= 6'h00;
			frame_clean_ff <= 1'b1;
		end else begin
			if (clk_tick)
				frame_ticks_ff <= frame_ticks_ff + 6'h01;
			if (sync_hit || wr_pend_ff)
				frame_clean_ff <= 1'b0;
		end
	end

	chk_frame_div_24: assert property (@(posedge clock) disable iff (rst) // RQ1
		(phase_end && phase_ff == last_phase && frame_clean_ff) |-> frame_ticks_ff == 6'd23)
		else $error("frame did not last 24 LCD clock ticks");

	chk_sync_restart: assert property (@(posedge clock) disable iff (rst) // RQ21
		sync_hit |=> (phase_ff == $past(last_phase) && sub_ff == 4'h0))
		else $error("sync did not restart the row sequence");

	chk_sync_driven: assert property (@(posedge clock) disable iff (rst) // RQ6
		($changed(phase_ff) && phase_ff == last_phase && !$past(wr_pend_ff)) |-> (sync_oe && !sync_out))
		else $error("sync line not pulled in the last phase");

	chk_row_step: assert property (@(posedge clock) disable iff (rst) // RQ20
		(phase_end && !sync_hit && phase_ff < last_phase) |=> phase_ff == $past(phase_ff) + 3'h1)
		else $error("row sequence skipped a phase");

	chk_latch_row: assert property (@(posedge clock) disable iff (rst) // RQ7
		(phase_end && !sync_hit && !wr_pend_ff) |=> latch_ff == ram_ff[row_of(phase_ff, mode_ff.mux)])
		else $error("latch does not hold the addressed row");

	chk_static_bps: assert property (@(posedge clock) disable iff (rst) // RQ11
		(mode_ff.mux == MUX_STATIC) [*2] |->
		(drive_ff.bp[0] == drive_ff.bp[1] && drive_ff.bp[1] == drive_ff.bp[2]
		&& drive_ff.bp[2] == drive_ff.bp[3]))
		else $error("static backplanes differ");

	chk_dup_bps: assert property (@(posedge clock) disable iff (rst) // RQ13
		(mode_ff.mux == MUX_2) [*2] |->
		(drive_ff.bp[0] == drive_ff.bp[2] && drive_ff.bp[1] == drive_ff.bp[3]))
		else $error("two-backplane pairs differ");

	chk_tri_bp3: assert property (@(posedge clock) disable iff (rst) // RQ14
		(mode_ff.mux == MUX_3) [*2] |-> drive_ff.bp[3] == drive_ff.bp[1])
		else $error("backplane 3 does not repeat backplane 1");

	chk_off_levels: assert property (@(posedge clock) disable iff (rst) // RQ19
		(!mode_ff.enable) [*2] |-> (&drive_ff))
		else $error("disabled display not parked at supply level");

	chk_bias_bypass: assert property (@(posedge clock) disable iff (rst) // RQ17
		$changed(mode_ff.half) |=> divider_bypass == $past(mode_ff.half))
		else $error("divider bypass does not follow half bias");

endmodule
`default_nettype wire

// ===== common/lcd_drive_pkg.sv
// Behaviour
// RQ1 - frame frequency is the selected LCD clock divided by twenty-four
// RQ2 - oscillator pin low: internal oscillator runs and drives the clock pin
// RQ3 - oscillator pin high: clock pin is an input timing all drive logic
// RQ4 - system must always supply a clock, else panel sits in DC
// RQ5 - host holds serial data high after power-on so oscillator starts
// RQ6 - cascaded devices align frame phase through a shared sync line
// RQ7 - display latch holds one row of segment data for its whole phase
// RQ8 - forty segment outputs formed from backplane phase and latch bit
// RQ9 - four backplane waveforms follow the selected drive mode
// RQ10 - static mode for one backplane, two levels, no fractional bias
// RQ11 - static mode drives the same waveform on all four backplanes
// RQ12 - two-backplane mode supports half or third bias by configuration
// RQ13 - two-backplane mode: backplanes 0 and 2 match, 1 and 3 match
// RQ14 - three-backplane mode: backplane 3 repeats backplane 1
// RQ15 - four-backplane mode sequences all four backplanes at third bias
// RQ16 - multiplex ratio and bias come from the drive-configuration command
// RQ17 - half bias bypasses the middle element of the bias divider
// RQ18 - half bias is also allowed in three- and four-backplane modes
// RQ19 - reset: four-backplane third bias, display off, all outputs at supply
// RQ20 - rows step 0..3, 0..2, 0..1 or 0 only by mode
// RQ21 - sync resets the sequence to row 3, 2, 1 or 0 by mode
// RQ22 - each phase encodes output levels; polarity alternates per frame, no DC; code inverts the second half of each frame instead
package lcd_drive_pkg;

	// timing
	localparam int CLOCK_HZ        = 100_000_000;
	localparam int INT_OSC_HZ      = 1536;
	localparam int OSC_HALF_CYCLES = CLOCK_HZ / (2 * INT_OSC_HZ);
	localparam int FRAME_DIV       = 24;
	localparam int NUM_SEG         = 40;
	localparam int NUM_BP          = 4;

	// register map, byte addresses
	localparam logic [7:0] MODE_OFS     = 8'h00;
	localparam logic [7:0] STATUS_OFS   = 8'h04;
	localparam logic [7:0] RAM_BASE_OFS = 8'h10;
	localparam logic [7:0] RAM_END_OFS  = 8'h2C;

	// mode register fields and reset value
	localparam int         MODE_WIDTH = 4;
	localparam logic [3:0] MODE_RESET = 4'h3;

	// status register fields
	localparam int STAT_PHASE_LSB  = 0;
	localparam int STAT_ROW_LSB    = 4;
	localparam int STAT_INTOSC_BIT = 8;
	localparam int STAT_BYPASS_BIT = 9;

	// bus constants
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [1:0] {
		MUX_STATIC = 2'b00,
		MUX_2      = 2'b01,
		MUX_3      = 2'b10,
		MUX_4      = 2'b11
	} mux_type;

	// drive levels; under half bias LVL_LOW stands for the half level
	typedef enum logic [1:0] {
		LVL_VSS  = 2'b00,
		LVL_LOW  = 2'b01,
		LVL_HIGH = 2'b10,
		LVL_LCD  = 2'b11
	} level_type;

	typedef struct packed {
		logic    enable;
		logic    half;
		mux_type mux;
	} mode_type;

	typedef struct packed {
		level_type [NUM_BP-1:0]  bp;
		level_type [NUM_SEG-1:0] seg;
	} drive_type;

endpackage

// ===== hw/lcd_clock_source.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_clock_source #(
	parameter int OSC_HALF_CYCLES = lcd_drive_pkg::OSC_HALF_CYCLES
) (
	// system
	input  wire logic clock,
	input  wire logic rst,
	// pins
	input  wire logic internal_oscillator_enable_pin,
	input  wire logic lcd_clk_in,
	output logic      lcd_clk_out,
	output logic      lcd_clk_oe,
	// to the sequencer
	output logic      clk_tick,
	output logic      internal_sel
);
	import lcd_drive_pkg::*;

	logic        osc_s1_ff;
	logic        osc_s2_ff;
	logic        ext_s1_ff;
	logic        ext_s2_ff;
	logic        ext_s3_ff;
	logic [15:0] div_ff;
	logic        osc_ff;
	logic        tick_ff;
	logic        sel_ff;

	// pins are asynchronous to the system clock, two stages each
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			osc_s1_ff <= 1'b1;
			osc_s2_ff <= 1'b1;
			ext_s1_ff <= 1'b0;
			ext_s2_ff <= 1'b0;
			ext_s3_ff <= 1'b0;
		end else begin
			osc_s1_ff <= internal_oscillator_enable_pin;
			osc_s2_ff <= osc_s1_ff;
			ext_s1_ff <= lcd_clk_in;
			ext_s2_ff <= ext_s1_ff;
			ext_s3_ff <= ext_s2_ff;
		end
	end

	// internal oscillator modelled as a divider of the system clock
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			div_ff <= 16'h0000;
			osc_ff <= 1'b0;
		end else if (div_ff == 16'(OSC_HALF_CYCLES - 1)) begin
			div_ff <= 16'h0000;
			osc_ff <= ~osc_ff;
		end else begin
			div_ff <= div_ff + 16'h0001;
		end
	end

	// source select and one tick per rising LCD clock edge
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sel_ff  <= 1'b0;
			tick_ff <= 1'b0;
		end else begin
			sel_ff <= ~osc_s2_ff; // RQ2 RQ3
			if (sel_ff)
				tick_ff <= ~osc_ff && (div_ff == 16'(OSC_HALF_CYCLES - 1)); // RQ2
			else
				tick_ff <= ext_s2_ff && ~ext_s3_ff; // RQ3
		end
	end

	// clock pin only driven when running from the internal oscillator
	assign lcd_clk_out  = osc_ff;
	assign lcd_clk_oe   = sel_ff; // RQ2
	assign clk_tick     = tick_ff;
	assign internal_sel = sel_ff;

	chk_int_clk_out: assert property (@(posedge clock) disable iff (rst) // RQ2
		(!osc_s2_ff) [*2] |-> lcd_clk_oe)
		else $error("internal oscillator selected but clock pin not driven");

	chk_ext_clk_tick: assert property (@(posedge clock) disable iff (rst) // RQ3
		(!sel_ff && ext_s2_ff && !ext_s3_ff) |=> (clk_tick && !lcd_clk_oe))
		else $error("external clock edge did not produce a tick");

endmodule
`default_nettype wire

// ===== testbench/lcd_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model #(
	parameter int EXT_HALF = 5
) (
	// system
	input  wire logic                     clock,
	// panel electrodes
	input  wire lcd_drive_pkg::drive_type panel_drive,
	// cascade neighbour
	input  wire logic                     sync_oe,
	input  wire logic                     sync_out,
	input  wire logic                     sync_pull,
	output logic                          sync_level,
	input  wire logic                     lcd_clk_oe,
	input  wire logic                     lcd_clk_out,
	output logic                          clk_pin
);
	import lcd_drive_pkg::*;
	typedef struct {
		drive_type drive;
		int        cyc;
		logic      so;
	} record_type;
	record_type log[$];
	drive_type  last_ff = '1;
	int         cyc_ff  = 0;
	int         age_ff  = 0;
	int         ext_cnt = 0;
	logic       ext_clk = 1'b0;

	// neighbour oscillator runs free, so the device is never left without a clock
	always @(posedge clock) begin
		if (ext_cnt == EXT_HALF - 1) begin
			ext_cnt <= 0;
			ext_clk <= ~ext_clk;
		end else begin
			ext_cnt <= ext_cnt + 1;
		end
	end
	assign clk_pin = lcd_clk_oe ? lcd_clk_out : ext_clk;
	// open-drain line with pull-up: low while either party pulls
	assign sync_level = ~((sync_oe & ~sync_out) | sync_pull);

	// log every level change; sync drive is sampled three cycles after each change, away from the edge
	always @(posedge clock) begin
		cyc_ff <= cyc_ff + 1;
		age_ff <= age_ff + 1;
		if (panel_drive !== last_ff) begin
			log.push_back('{panel_drive, cyc_ff, 1'b0});
			last_ff <= panel_drive;
			age_ff  <= 0;
		end
		if (age_ff == 2 && log.size() > 0)
			log[log.size()-1].so = sync_oe;
	end
endmodule
`default_nettype wire

// ===== testbench/lcd_multiplex_drive_bench.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_multiplex_drive_bench;
	import lcd_drive_pkg::*;
	localparam int LIMIT = 40000;
	logic        clock, rst, hsel, hwrite, osc_pin, sync_pull;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, lcd_clk_out, lcd_clk_oe, sync_out, sync_oe, divider_bypass;
	logic        clk_pin, sync_level, osc_seen;
	drive_type   panel_drive;
	logic [39:0] ram [4];
	logic [3:0]  mtab [7] = '{4'h8, 4'h9, 4'hD, 4'hA, 4'hE, 4'hB, 4'hF};
	int          fails = 0;
	int          check_count = 0;
	int          ticks = 0;

	lcd_multiplex_drive #(.OSC_HALF_CYCLES(4)) dut_u (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .internal_oscillator_enable_pin(osc_pin),
		.lcd_clk_in(clk_pin), .lcd_clk_out(lcd_clk_out), .lcd_clk_oe(lcd_clk_oe), .sync_in(sync_level),
		.sync_out(sync_out), .sync_oe(sync_oe), .panel_drive(panel_drive), .divider_bypass(divider_bypass));
	lcd_panel_model #(.EXT_HALF(5)) panel_u (.clock(clock), .panel_drive(panel_drive), .sync_oe(sync_oe),
		.sync_out(sync_out),
		.sync_pull(sync_pull), .sync_level(sync_level), .lcd_clk_oe(lcd_clk_oe), .lcd_clk_out(lcd_clk_out),
		.clk_pin(clk_pin));

	task automatic conclude();
		if (fails == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [95:0] seen, input logic [95:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one single word transfer; entered just after a rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdv);
		haddr  <= {24'h000000, a};
		hwrite <= wr;
		htrans <= HTRANS_NONSEQ;
		hsel   <= 1'b1;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		rdv = hrdata;
	endtask

	// expected levels of phase p; second half of the frame is the inverted copy
	function automatic drive_type expd(input logic [3:0] m, input int p);
		drive_type d;
		int        rows, row, lb;
		logic      inv, on;
		rows = int'(m[1:0]) + 1;
		row  = p % rows;
		inv  = (p >= rows);
		for (int b = 0; b < 4; b++) begin
			lb = (m[1:0] == 2'h1) ? b % 2 : (m[1:0] == 2'h2 && b == 3) ? 1 : b;
			if (m[1:0] == 2'h0)
				d.bp[b] = inv ? LVL_LCD : LVL_VSS;
			else if (lb == row)
				d.bp[b] = inv ? LVL_VSS : LVL_LCD;
			else
				d.bp[b] = (m[2] || !inv) ? LVL_LOW : LVL_HIGH;
		end
		for (int s = 0; s < 40; s++) begin
			on = ram[row][s];
			if (m[1:0] == 2'h0)
				d.seg[s] = (on ^ inv) ? LVL_LCD : LVL_VSS;
			else if (on)
				d.seg[s] = inv ? LVL_LCD : LVL_VSS;
			else if (m[2])
				d.seg[s] = inv ? LVL_VSS : LVL_LCD;
			else
				d.seg[s] = inv ? LVL_LOW : LVL_HIGH;
		end
		return d;
	endfunction

	// one frame in mode m with tick period tp, then a sync restart from phase 0
	task automatic frame(input logic [3:0] m, input int tp);
		int r, i, n;
		r = int'(m[1:0]) + 1;
		i = 0;
		bus(1'b1, MODE_OFS, {28'h0000000, m}, rd);
		repeat (30 * tp) @(posedge clock);
		panel_u.log.delete();
		while (panel_u.log.size() < 4 * r + 1) @(posedge clock);
		while (i < 2 * r - 1 && panel_u.log[i].drive !== expd(m, 0)) i++;
		for (int k = 0; k < 2 * r; k++)
			check(panel_u.log[i+k].drive, expd(m, k));
		check(panel_u.log[i+1].cyc - panel_u.log[i].cyc, 12 / r * tp);
		check(panel_u.log[i+2*r].cyc - panel_u.log[i].cyc, 24 * tp);
		check(panel_u.log[i+2*r-1].so, 1'b1);
		check(panel_u.log[i].so, 1'b0);
		while (panel_u.log[panel_u.log.size()-1].drive !== expd(m, 0)) @(posedge clock);
		n = panel_u.log.size();
		sync_pull <= 1'b1;
		repeat (3) @(posedge clock);
		sync_pull <= 1'b0;
		while (panel_u.log.size() < n + 3) @(posedge clock);
		check(panel_u.log[n].drive, expd(m, 2 * r - 1));
		check(panel_u.log[n+1].drive, expd(m, 0));
		// the restarted phase is cut short by where the sync falls between ticks,
		// so the full phase length is taken from the one after it
		check(panel_u.log[n+2].cyc - panel_u.log[n+1].cyc, 12 / r * tp);
	endtask

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// a hang ends the run as a failure
	always @(posedge clock) begin
		ticks <= ticks + 1;
		if (ticks == LIMIT) begin
			fails++;
			conclude();
		end
	end

	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		osc_pin = 1'b0;
		sync_pull = 1'b0;
		repeat (3) @(posedge clock);
		check(panel_drive, {88{1'b1}});
		check(lcd_clk_oe, 1'b0);
		rst <= 1'b0;
		@(posedge clock);
		bus(1'b0, MODE_OFS, 32'h0, rd);
		check(rd, MODE_RESET);
		check(hresp, 1'b0);
		for (int r = 0; r < 4; r++) begin
			ram[r] = 40'hA5C3A50F96 ^ {10{4'(r + 1)}};
			bus(1'b1, 8'(RAM_BASE_OFS + 8 * r), ram[r][31:0], rd);
			bus(1'b1, 8'(RAM_BASE_OFS + 8 * r + 4), {24'h000000, ram[r][39:32]}, rd);
		end
		bus(1'b0, 8'(RAM_BASE_OFS + 16), 32'h0, rd);
		check(rd, ram[2][31:0]);
		bus(1'b0, 8'h40, 32'h0, rd);
		check(rd, 32'h0);
		bus(1'b0, STATUS_OFS, 32'h0, rd);
		check(rd[STAT_INTOSC_BIT], 1'b1);
		check(lcd_clk_oe, 1'b1);
		// oscillator must be running: one half period is four system cycles here
		osc_seen = lcd_clk_out;
		repeat (4) @(posedge clock);
		check(lcd_clk_out, !osc_seen);
		foreach (mtab[j])
			frame(mtab[j], 8);
		repeat (3) @(posedge clock);
		check(divider_bypass, 1'b1);
		bus(1'b0, STATUS_OFS, 32'h0, rd);
		check(rd[STAT_BYPASS_BIT], 1'b1);
		bus(1'b1, MODE_OFS, 32'h3, rd);
		repeat (200) @(posedge clock);
		check(panel_drive, {88{1'b1}});
		check(divider_bypass, 1'b0);
		osc_pin <= 1'b1;
		repeat (20) @(posedge clock);
		check(lcd_clk_oe, 1'b0);
		bus(1'b0, STATUS_OFS, 32'h0, rd);
		check(rd[STAT_INTOSC_BIT], 1'b0);
		frame(4'hB, 10);
		conclude();
	end
endmodule
`default_nettype wire
